/* File: design/scpm_top.sv */
// Purpose: system clock selection and operating mode control
// Assumes: pclk is the high speed source; low speed sources arrive as enable ticks
// Notes:   every clock output is a one-cycle enable, registered
`include "scpm_map.svh"

// Summary of operation
// - select system clock from high or low
// - normal mode: high source divided 1 to 64
// - low clock source fixed by option input
// - substitute and time base sources by option
// - substitute clock runs cpu after wake-up
// - low selected stops high oscillator and clocks
// - watchdog from sysclk/4 or substitute clock
// - low oscillators feed watchdog, time base
// - normal mode: all clocks active
// - slow mode: cpu on low, high off
// - halt without idle enable enters sleep
// - all-off sleep blocked while lvd enabled
// - retain sleep keeps substitute when needed
// - halt, idle, no keep: oscillator-off idle
// - oscillator-off idle: watchdog only from substitute
// - halt, idle, keep: oscillator-on idle
// - oscillator-on idle: watchdog clock runs
// - idle keeps peripheral clocks available
// - divider field: 0,1 low; 2..7 /64../2
// - low ready flag: 1024 or 2 ticks
module scpm_top
    import scpm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        lxt_tick,
    input  wire logic        internal_low_speed_rc_tick,
    input  wire logic        cfg_low_from_lxt,
    input  wire logic        cfg_sub_from_lxt,
    input  wire logic        cfg_tbc_from_lxt,
    input  wire logic        cfg_wdt_from_sub,
    input  wire logic        cfg_wdt_enable,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    output logic             cpu_clk_en,
    output logic             sys_clk_en,
    output logic             high_clk_en,
    output logic             sub_clk_en,
    output logic             tbc_clk_en,
    output logic             wdt_clk_en,
    output logic             wdt_run,
    output logic             high_osc_enable,
    output logic             low_osc_enable,
    output scpm_mode_t       op_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic sel_low(input logic hl, input logic [2:0] cks);
        sel_low = !hl && (cks[2:1] == 2'h0);
    endfunction

    function automatic logic [2:0] sel_log2(input logic hl, input logic [2:0] cks);
        sel_log2 = hl ? 3'h0 : 3'(4'h8 - {1'b0, cks});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [2:0]  cks;
    logic        fast_wake;
    logic        idle_on_halt_enable;
    logic        high_low_clock_select;
    logic        idle_system_clock_keep;
    logic        low_voltage_detect_enable;
    logic        low_speed_ready_flag;
    logic        high_ready;
    logic [10:0] lto_cnt;
    logic [10:0] hto_cnt;
    scpm_mode_t  next_mode;

    wire  acc      = psel & penable & pready;
    wire  wr_acc   = acc & pwrite & pstrb[0];
    wire  hit_mode = (paddr == `SCPM_ADDR_MODE);
    wire  hit_mod2 = (paddr == `SCPM_ADDR_MODE2);
    wire  hit_stat = (paddr == `SCPM_ADDR_STATUS);
    wire  mapped   = hit_mode | hit_mod2 | hit_stat;

    wire [7:0] mode_rd = {cks, fast_wake, low_speed_ready_flag, high_ready,
                          idle_on_halt_enable, high_low_clock_select};
    wire [7:0] mod2_rd = {6'h00, low_voltage_detect_enable, idle_system_clock_keep};
    wire [31:0] next_prdata = hit_mode ? {24'h0, mode_rd} :
                              hit_mod2 ? {24'h0, mod2_rd} :
                              hit_stat ? {29'h0, op_mode} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & !pready;
            prdata  <= (psel & !pwrite) ? next_prdata : 32'h0;
            pslverr <= psel & penable & !pready & !mapped;
        end
    end

    localparam logic [7:0] mode_rst = `SCPM_MODE_RST;
    localparam logic [7:0] mod2_rst = `SCPM_MODE2_RST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cks                   <= mode_rst[`SCPM_CKS_MSB:`SCPM_CKS_LSB];
            fast_wake             <= mode_rst[`SCPM_FAST_BIT];
            idle_on_halt_enable   <= mode_rst[`SCPM_IDLE_ON_HALT_ENABLE_BIT];
            high_low_clock_select <= mode_rst[`SCPM_HIGH_LOW_CLOCK_SELECT_BIT];
        end else if (wr_acc && hit_mode) begin
            cks                   <= pwdata[`SCPM_CKS_MSB:`SCPM_CKS_LSB];
            fast_wake             <= pwdata[`SCPM_FAST_BIT];
            idle_on_halt_enable   <= pwdata[`SCPM_IDLE_ON_HALT_ENABLE_BIT];
            high_low_clock_select <= pwdata[`SCPM_HIGH_LOW_CLOCK_SELECT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_system_clock_keep    <= mod2_rst[`SCPM_KEEP_BIT];
            low_voltage_detect_enable <= mod2_rst[`SCPM_LVD_BIT];
        end else if (wr_acc && hit_mod2) begin
            idle_system_clock_keep    <= pwdata[`SCPM_KEEP_BIT];
            low_voltage_detect_enable <= pwdata[`SCPM_LVD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock sources and dividers
    wire use_low  = sel_low(high_low_clock_select, cks);
    wire low_on   = (op_mode != SCPM_SLEEP_ALL_OFF_MODE);
    wire low_tick = low_on & (cfg_low_from_lxt ? lxt_tick : internal_low_speed_rc_tick);
    wire sub_src  = low_on & (cfg_sub_from_lxt ? lxt_tick : internal_low_speed_rc_tick);
    wire tbc_src  = low_on & (cfg_tbc_from_lxt ? lxt_tick : internal_low_speed_rc_tick);
    wire hdiv_tick;
    wire wdiv_tick;
    wire sys_tick;

    scpm_clk_div u_hdiv (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (1'b1),
        .enable   (high_osc_enable & high_ready),
        .div_log2 (sel_log2(high_low_clock_select, cks)),
        .tick     (hdiv_tick)
    );

    scpm_clk_div u_wdiv (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (sys_tick),
        .enable   (1'b1),
        .div_log2 (`SCPM_WDT_DIV_LOG2),
        .tick     (wdiv_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // oscillator ready flags
    wire [10:0] lto_target = cfg_low_from_lxt ? `SCPM_LXT_READY_CNT : `SCPM_INTERNAL_LOW_SPEED_RC_READY_CNT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lto_cnt              <= 11'h000;
            low_speed_ready_flag <= 1'b0;
        end else if (!low_on || (next_mode == SCPM_SLEEP_ALL_OFF_MODE)) begin
            lto_cnt              <= 11'h000;
            low_speed_ready_flag <= 1'b0;
        end else if (low_tick && !low_speed_ready_flag) begin
            lto_cnt              <= lto_cnt + 11'h001;
            low_speed_ready_flag <= (lto_cnt + 11'h001) >= lto_target;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hto_cnt    <= 11'h000;
            high_ready <= 1'b0;
        end else if (!high_osc_enable) begin
            hto_cnt    <= 11'h000;
            high_ready <= 1'b0;
        end else if (!high_ready) begin
            hto_cnt    <= hto_cnt + 11'h001;
            high_ready <= (hto_cnt + 11'h001) >= `SCPM_HTO_CNT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operating mode sequencer
    wire running   = (op_mode == SCPM_NORMAL) || (op_mode == SCPM_SLOW);
    wire retain    = low_voltage_detect_enable | (cfg_wdt_enable & cfg_wdt_from_sub);

    always_comb begin
        next_mode = op_mode;
        case (op_mode)
            SCPM_NORMAL, SCPM_SLOW: begin
                if (halt_req) begin
                    if (!idle_on_halt_enable) begin
                        next_mode = retain ? SCPM_SLEEP_CLOCK_RETAIN_MODE : SCPM_SLEEP_ALL_OFF_MODE;
                    end else if (idle_system_clock_keep) begin
                        next_mode = SCPM_IDLE_OSCILLATOR_ON_MODE;
                    end else begin
                        next_mode = SCPM_IDLE_OSCILLATOR_OFF_MODE;
                    end
                end else begin
                    next_mode = use_low ? SCPM_SLOW : SCPM_NORMAL;
                end
            end
            SCPM_IDLE_OSCILLATOR_OFF_MODE, SCPM_IDLE_OSCILLATOR_ON_MODE, SCPM_SLEEP_ALL_OFF_MODE, SCPM_SLEEP_CLOCK_RETAIN_MODE: begin
                if (wake_req) begin
                    next_mode = use_low ? SCPM_SLOW : SCPM_NORMAL;
                end
            end
            default: next_mode = SCPM_NORMAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock gating per mode
    wire sys_on   = (op_mode == SCPM_NORMAL) || (op_mode == SCPM_SLOW) ||
                    (op_mode == SCPM_IDLE_OSCILLATOR_ON_MODE);
    assign sys_tick = sys_on & (use_low ? low_tick : hdiv_tick);
    wire cpu_tick = running & (use_low ? low_tick :
                    (high_ready ? hdiv_tick : (fast_wake & sub_src)));
    wire sub_on   = (op_mode == SCPM_SLEEP_CLOCK_RETAIN_MODE) ? retain : low_on;
    wire tbc_on   = (op_mode != SCPM_SLEEP_ALL_OFF_MODE) && (op_mode != SCPM_SLEEP_CLOCK_RETAIN_MODE);
    wire wdt_on   = (op_mode == SCPM_SLEEP_ALL_OFF_MODE) ? 1'b0 :
                    (op_mode == SCPM_SLEEP_CLOCK_RETAIN_MODE) ? retain : 1'b1;
    wire wdt_tick = wdt_on & (cfg_wdt_from_sub ? sub_src : wdiv_tick);
    wire next_hosc = !sel_low(high_low_clock_select, cks) &&
                     ((next_mode == SCPM_NORMAL) || (next_mode == SCPM_IDLE_OSCILLATOR_ON_MODE));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode         <= SCPM_NORMAL;
            cpu_clk_en      <= 1'b0;
            sys_clk_en      <= 1'b0;
            high_clk_en     <= 1'b0;
            sub_clk_en      <= 1'b0;
            tbc_clk_en      <= 1'b0;
            wdt_clk_en      <= 1'b0;
            wdt_run         <= 1'b0;
            high_osc_enable <= 1'b0;
            low_osc_enable  <= 1'b0;
        end else begin
            op_mode         <= next_mode;
            cpu_clk_en      <= cpu_tick;
            sys_clk_en      <= sys_tick;
            high_clk_en     <= high_osc_enable & high_ready;
            sub_clk_en      <= sub_on & sub_src;
            tbc_clk_en      <= tbc_on & tbc_src;
            wdt_clk_en      <= wdt_tick;
            wdt_run         <= cfg_wdt_enable & (op_mode != SCPM_SLEEP_ALL_OFF_MODE);
            high_osc_enable <= next_hosc;
            low_osc_enable  <= (next_mode != SCPM_SLEEP_ALL_OFF_MODE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_halt_sleep;
        running && halt_req && !idle_on_halt_enable;
    endsequence

    sequence s_halt_idle;
        running && halt_req && idle_on_halt_enable;
    endsequence

    a_sleep_entry: assert property (s_halt_sleep |=>
        (op_mode == SCPM_SLEEP_ALL_OFF_MODE) || (op_mode == SCPM_SLEEP_CLOCK_RETAIN_MODE))
        else $error("halt without idle enable missed sleep");
    a_lvd_blocks_sleep_all_off_mode: assert property (
        s_halt_sleep ##0 low_voltage_detect_enable |=> op_mode == SCPM_SLEEP_CLOCK_RETAIN_MODE)
        else $error("all-off sleep entered with lvd set");
    a_idle_oscillator_off_mode_entry: assert property (
        s_halt_idle ##0 !idle_system_clock_keep |=> op_mode == SCPM_IDLE_OSCILLATOR_OFF_MODE && !high_osc_enable)
        else $error("oscillator-off idle not entered");
    a_idle_oscillator_on_mode_entry: assert property (s_halt_idle ##0 idle_system_clock_keep |=>
        op_mode == SCPM_IDLE_OSCILLATOR_ON_MODE)
        else $error("oscillator-on idle not entered");
    a_wake_resume: assert property (!running && wake_req |=>
        op_mode == ($past(use_low) ? SCPM_SLOW : SCPM_NORMAL))
        else $error("wake did not resume selected run mode");
    a_slow_high_off: assert property (op_mode == SCPM_SLOW && use_low |=>
        !high_osc_enable ##1 !high_clk_en)
        else $error("high clock alive in slow mode");
    a_idle_oscillator_off_mode_wdt_off: assert property (op_mode == SCPM_IDLE_OSCILLATOR_OFF_MODE && !cfg_wdt_from_sub |=>
        !wdt_clk_en)
        else $error("watchdog clock from sysclk in oscillator-off idle");
    a_sleep_all_off_mode_clocks: assert property (op_mode == SCPM_SLEEP_ALL_OFF_MODE |=>
        !sub_clk_en && !wdt_clk_en && !tbc_clk_en && !wdt_run && !cpu_clk_en)
        else $error("clock running in all-off sleep");
    a_sleep_all_off_mode_lto_low: assert property (op_mode == SCPM_SLEEP_ALL_OFF_MODE |->
        !low_speed_ready_flag)
        else $error("low ready flag high in all-off sleep");
    a_fast_wake_sub: assert property (op_mode == SCPM_NORMAL && !high_ready &&
        !use_low && fast_wake && sub_src |=> cpu_clk_en)
        else $error("substitute clock not used after wake");
    a_halted_cpu: assert property (!running |=> !cpu_clk_en)
        else $error("cpu clocked while halted");
endmodule // scpm_top

/* File: design/scpm_map.svh */
// Purpose: offsets, field positions, reset values and counts of the clock and mode block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef SCPM_MAP_SVH
`define SCPM_MAP_SVH
`define SCPM_ADDR_MODE      12'h000
`define SCPM_ADDR_MODE2     12'h004
`define SCPM_ADDR_STATUS    12'h008
`define SCPM_CKS_MSB        7
`define SCPM_CKS_LSB        5
`define SCPM_FAST_BIT       4
`define SCPM_LTO_BIT        3
`define SCPM_HTO_BIT        2
`define SCPM_IDLE_ON_HALT_ENABLE_BIT      1
`define SCPM_HIGH_LOW_CLOCK_SELECT_BIT      0
`define SCPM_KEEP_BIT       0
`define SCPM_LVD_BIT        1
`define SCPM_MODE_RST       8'h03
`define SCPM_MODE2_RST      8'h00
`define SCPM_LXT_READY_CNT  11'h400
`define SCPM_INTERNAL_LOW_SPEED_RC_READY_CNT 11'h002
`define SCPM_HTO_CNT        11'h010
`define SCPM_WDT_DIV_LOG2   3'h2
`endif

/* File: design/scpm_pkg.sv */
// Purpose: types of the clock and mode block
// Assumes: nothing
// Notes:   mode order is also the status register encoding
package scpm_pkg;
    typedef enum logic [2:0] {
        SCPM_NORMAL,
        SCPM_SLOW,
        SCPM_IDLE_OSCILLATOR_OFF_MODE,
        SCPM_IDLE_OSCILLATOR_ON_MODE,
        SCPM_SLEEP_ALL_OFF_MODE,
        SCPM_SLEEP_CLOCK_RETAIN_MODE
    } scpm_mode_t;
endpackage

/* File: design/scpm_clk_div.sv */
// Purpose: power-of-two enable divider
// Assumes: src_tick is a one-cycle enable
// Notes:   tick is one pulse each 2**div_log2 source ticks for div_log2 0..6; 7 also gives 64
module scpm_clk_div
    import scpm_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       src_tick,
    input  wire logic       enable,
    input  wire logic [2:0] div_log2,
    output logic            tick
);
    logic [5:0] cnt;
    wire  [5:0] mask = 6'((7'h01 << div_log2) - 7'h01);

    assign tick = src_tick & enable & ((cnt & mask) == mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 6'h00;
        end else if (!enable) begin
            cnt <= 6'h00;
        end else if (src_tick) begin
            cnt <= cnt + 6'h01;
        end
    end
endmodule // scpm_clk_div

/* File: verification/scpm_osc_model.sv */
// Purpose: low speed oscillator model driving the clock block
// Assumes: each tick lasts one pclk cycle
// Notes:   ticks only while the block asks the low oscillators to run
module scpm_osc_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      lxt_tick,
    output logic      internal_low_speed_rc_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] phase;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 4'h0;
        end else if (run) begin
            phase <= phase + 4'h1;
        end
    end
    assign internal_low_speed_rc_tick = run && (phase[2:0] == 3'h7);
    assign lxt_tick  = run && (phase == 4'hf);
endmodule // scpm_osc_model

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the clock and mode block
// Assumes: apb master, low oscillators from the partner model
// Notes:   counts clock enables over fixed windows
module testbench;
    import scpm_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        lxt_tick;
    logic        internal_low_speed_rc_tick;
    logic [4:0]  cfg;
    logic        halt_req;
    logic        wake_req;
    logic        cpu_en;
    logic        sys_en;
    logic        high_en;
    logic        sub_en;
    logic        tbc_en;
    logic        wdt_en;
    logic        wdt_run;
    logic        high_osc;
    logic        low_osc;
    scpm_mode_t  op_mode;
    logic [31:0] r;
    logic        e;
    int          err_count;
    int          n_compared;
    int          c_sys;
    int          c_sub;
    int          c_wdt;
    int          c_cpu;
    int          c_high;
    int          c_tbc;

    scpm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .lxt_tick(lxt_tick), .internal_low_speed_rc_tick(internal_low_speed_rc_tick),
        .cfg_low_from_lxt(cfg[0]), .cfg_sub_from_lxt(cfg[1]), .cfg_tbc_from_lxt(cfg[2]),
        .cfg_wdt_from_sub(cfg[3]), .cfg_wdt_enable(cfg[4]), .halt_req(halt_req),
        .wake_req(wake_req), .cpu_clk_en(cpu_en), .sys_clk_en(sys_en),
        .high_clk_en(high_en), .sub_clk_en(sub_en), .tbc_clk_en(tbc_en),
        .wdt_clk_en(wdt_en), .wdt_run(wdt_run), .high_osc_enable(high_osc),
        .low_osc_enable(low_osc), .op_mode(op_mode));
    scpm_osc_model osc (.pclk(pclk), .presetn(presetn), .run(low_osc),
        .lxt_tick(lxt_tick), .internal_low_speed_rc_tick(internal_low_speed_rc_tick));

    always #2.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            err_count++;
            $display("ERROR apb ready expected 1 seen %b", pready);
        end
    endtask

    task automatic count(input int n);
        {c_sys, c_sub, c_wdt, c_cpu, c_high, c_tbc} = '0;
        repeat (n) begin
            @(posedge pclk);
            c_sys += (sys_en === 1'b1);
            c_sub += (sub_en === 1'b1);
            c_wdt += (wdt_en === 1'b1);
            c_cpu += (cpu_en === 1'b1);
            c_high += (high_en === 1'b1);
            c_tbc += (tbc_en === 1'b1);
        end
    endtask

    task automatic set_mode(input logic [2:0] cks, input logic idl, input logic hl);
        apb(1'b1, 12'h000, {24'h000000, cks, 3'h0, idl, hl});
        repeat (70) @(posedge pclk);
    endtask

    task automatic pulse(input logic wake);
        if (wake) wake_req <= 1'b1;
        else halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        check("mode reset", r & 32'hfffffff3, 32'h00000003);
        apb(1'b0, 12'h004, 32'h0);
        check("mode2 reset", r, 32'h00000000);
        apb(1'b1, 12'h008, 32'h00000005);
        apb(1'b0, 12'h008, 32'h0);
        check("status", r, 32'h00000000);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", {31'h0, e}, 32'h1);
    endtask

    task automatic t_div;
        for (int k = 2; k < 8; k++) begin
            set_mode(k[2:0], 1'b1, 1'b0);
            count(128);
            check("sys divided", c_sys, 128 >> (8 - k));
            check("normal mode", op_mode, SCPM_NORMAL);
        end
        set_mode(3'h0, 1'b1, 1'b1);
        count(128);
        check("sys undivided", c_sys, 128);
        check("cpu runs", c_cpu, 128);
        check("sub runs", c_sub != 0, 1);
    endtask

    task automatic t_slow;
        for (int k = 0; k < 2; k++) begin
            set_mode(k[2:0], 1'b0, 1'b0);
            count(128);
            check("slow mode", op_mode, SCPM_SLOW);
            check("high osc off", high_osc, 0);
            check("high clock off", c_high, 0);
            check("wdt from sys/4", c_wdt != 0, 1);
        end
        pulse(1'b0);
        check("sleep from slow", op_mode, SCPM_SLEEP_ALL_OFF_MODE);
        pulse(1'b1);
        check("wake to slow", op_mode, SCPM_SLOW);
    endtask

    task automatic t_sleep;
        set_mode(3'h0, 1'b0, 1'b1);
        pulse(1'b0);
        count(128);
        check("sleep_all_off_mode", op_mode, SCPM_SLEEP_ALL_OFF_MODE);
        check("sleep_all_off_mode clocks", c_sub + c_wdt + c_cpu + c_tbc, 0);
        check("wdt stopped", wdt_run, 0);
        check("low osc off", low_osc, 0);
        pulse(1'b1);
        check("wake normal", op_mode, SCPM_NORMAL);
        apb(1'b1, 12'h004, 32'h00000002);
        pulse(1'b0);
        count(128);
        check("sleep_clock_retain_mode", op_mode, SCPM_SLEEP_CLOCK_RETAIN_MODE);
        check("sleep_clock_retain_mode sub", c_sub != 0, 1);
        check("sleep_clock_retain_mode cpu tbc", c_cpu + c_tbc, 0);
        pulse(1'b1);
        apb(1'b1, 12'h004, 32'h00000000);
    endtask

    task automatic t_idle;
        set_mode(3'h0, 1'b1, 1'b1);
        for (int k = 0; k < 3; k++) begin
            cfg[3] <= (k == 1);
            if (k == 2) apb(1'b1, 12'h004, 32'h00000001);
            pulse(1'b0);
            count(128);
            check("idle mode", op_mode, k == 2 ? SCPM_IDLE_OSCILLATOR_ON_MODE : SCPM_IDLE_OSCILLATOR_OFF_MODE);
            check("idle cpu", c_cpu, 0);
            check("idle wdt", c_wdt != 0, k != 0);
            check("idle tbc", c_tbc != 0, 1);
            if (k == 2) check("idle_oscillator_on_mode sys", c_sys != 0, 1);
            pulse(1'b1);
            check("idle wake", op_mode, SCPM_NORMAL);
        end
    endtask

    task automatic t_fast;
        apb(1'b1, 12'h004, 32'h00000000);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h000, {24'h000000, 3'h0, k[0], 2'h0, 1'b1, 1'b1});
            repeat (40) @(posedge pclk);
            pulse(1'b0);
            check("fast idle_oscillator_off_mode", op_mode, SCPM_IDLE_OSCILLATOR_OFF_MODE);
            pulse(1'b1);
            count(10);
            check("fast wake cpu", c_cpu != 0, k);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, halt_req, wake_req} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cfg = 5'h10;
        err_count = 0;
        n_compared = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        t_regs;
        t_div;
        t_slow;
        t_sleep;
        t_idle;
        t_fast;
        print_verdict;
    end

    initial begin
        #200000;
        err_count++;
        $display("ERROR watchdog expected end seen hang");
        print_verdict;
    end
endmodule // testbench
